// *** sim/pct_timer_tb.sv ***
`timescale 1ns/1ps
module pct_timer_tb;
	import pct_pkg::*;
	logic clock; // 40 MHz
	logic sys_rst; // Synchronous reset
	pct_dm_req_type req; // Data memory access
	logic gdis; // Global disable
	logic ack; // Flag clear pulse
	logic [15:0] rdata; // Read data
	logic irq, pend, serv; // Event, flag, service
	int fails = 0, total_checks = 0, n;
	int lim = 32'h0000012c; // Wait bound in cycles
	pct_timer dut (.clock(clock), .sys_rst(sys_rst), .dm_req(req),
		.global_irq_disable(gdis), .irq_ack(ack), .dm_rdata(rdata),
		.countdown_irq(irq), .irq_pending(pend), .irq_service(serv));
	// Free-running clock
	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Verdict, the only place the run ends
	task wrap_up;
		if (fails == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// One write, taken at the second edge
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		req.wr <= 1; req.addr <= a; req.wdata <= d;
		@(posedge clock);
		req.wr <= 0;
	endtask
	// One read, data settles just after the taking edge
	task rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clock);
		req.rd <= 1; req.addr <= a;
		@(posedge clock);
		req.rd <= 0;
		#1 check(rdata, exp);
	endtask
	// Cycles until next event; bounded so a dead timer cannot hang
	task wait_irq;
		n = 0;
		do begin
			@(posedge clock);
			#1 n++;
		end while (!irq && n < lim);
		if (!irq) begin
			fails++;
			wrap_up;
		end
	endtask
	// Count held in reset, first decrement right after release
	task reset_scn;
		repeat (20) @(posedge clock);
		sys_rst <= 0; req.rd <= 1; req.addr <= COUNTDOWN_ADDR;
		@(posedge clock); #1 check(rdata, COUNTDOWN_RST);
		@(posedge clock); req.addr <= RELOAD_ADDR; #1 check(rdata, 16'hfffe);
		@(posedge clock); req.rd <= 0; #1 check(rdata, RELOAD_RST);
		rd(16'h0005, 16'h0000);
	endtask
	// Both registers loaded: no event, period is reload plus one
	task period_scn;
		wr(RELOAD_ADDR, 16'h0002);
		wr(COUNTDOWN_ADDR, 16'h0002);
		wait_irq; check(n[15:0], 16'h0002);
		wait_irq; check(n[15:0], 16'h0003);
	endtask
	// Reload alone leaves the running count alone
	task reload_scn;
		wr(RELOAD_ADDR, 16'h0004);
		wait_irq; check(n[15:0], 16'h0001);
		wait_irq; check(n[15:0], 16'h0005);
	endtask
	// Flag, mask bit of weight 8, clear by ack and by flag write; global disable set after the next event sets the flag again, service drops
	task irq_scn;
		check(serv, 1'b0);
		wr(IRQ_MASK_ADDR, 16'h0008);
		rd(IRQ_MASK_ADDR, 16'h0008);
		wait_irq;
		@(posedge clock); ack <= 1;
		@(posedge clock); ack <= 0; #1 check(pend, 1'b0);
		wait_irq;
		@(posedge clock); #1 check(pend, 1'b1);
		@(posedge clock); #1 check(serv, 1'b1);
		wr(IRQ_FLAG_ADDR, 16'h0008);
		rd(IRQ_FLAG_ADDR, 16'h0000);
		@(posedge clock); gdis <= 1;
		repeat (2) @(posedge clock);
		#1 check(serv, 1'b0);
	endtask
	// Smallest legal reload gives an event every two cycles
	task short_scn;
		wr(RELOAD_ADDR, 16'h0001);
		wait_irq;
		wait_irq; check(n[15:0], 16'h0002);
		wait_irq; check(n[15:0], 16'h0002);
	endtask
	// Largest reload: full sixteen-bit period between events
	task long_scn;
		wr(RELOAD_ADDR, 16'hffff);
		lim = 32'h00011170;
		wait_irq; check(n, 32'h00010000);
	endtask
	// Main sequence
	initial begin
		sys_rst = 1; req = '0; gdis = 0; ack = 0;
		reset_scn;
		period_scn;
		reload_scn;
		irq_scn;
		short_scn;
		long_scn;
		wrap_up;
	end
endmodule

// *** verilog/pct_pkg.sv ***
// Shared constants and carriers for the periodic countdown timer
package pct_pkg;
	localparam int DATA_W = 16; // Data word width
	localparam int ADDR_W = 16; // Data memory address width
	// Data memory locations of the timer registers
	localparam logic [ADDR_W-1:0] COUNTDOWN_ADDR = 16'h0002;
	localparam logic [ADDR_W-1:0] RELOAD_ADDR = 16'h0003;
	localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 16'h0004;
	localparam logic [ADDR_W-1:0] IRQ_FLAG_ADDR = 16'h0006;
	// Reset values
	localparam logic [DATA_W-1:0] COUNTDOWN_RST = 16'hffff;
	localparam logic [DATA_W-1:0] RELOAD_RST = 16'hffff;
	localparam logic [DATA_W-1:0] IRQ_MASK_RST = 16'h0000;
	// Timer bit position in mask and flag registers (weight 8)
	localparam int TIMER_BIT = 3;
	// Count value that marks the end of a period
	localparam logic [DATA_W-1:0] COUNT_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] COUNT_ONE = 16'h0001;
	// Data memory access carried into the timer
	typedef struct packed {
		logic [ADDR_W-1:0] addr; // Word address
		logic wr; // Write strobe
		logic rd; // Read strobe
		logic [DATA_W-1:0] wdata; // Write data
	} pct_dm_req_type;
endpackage

// *** verilog/pct_timer.sv ***
`timescale 1ns/1ps
// Function
// - Sixteen-bit counter with interrupt output
// - Counts down, period is reload plus one
// - Reload 1..65535 gives interrupt every 2..65536
// - Count at location 2, decrements each cycle
// - Reload length at location 3
// - Interrupt request when count reaches zero
// - Cycle after zero, reload copied into count
// - Both registers readable and writable any cycle
// - Reload write alone leaves count undisturbed
// - Count write restarts period, no interrupt
// - Reset sets both registers to all ones
// - Count holds in reset, runs after release
// - Flag set; service needs mask, global enable
module pct_timer
	import pct_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire pct_dm_req_type dm_req,
	input wire logic global_irq_disable,
	input wire logic irq_ack,
	output logic [DATA_W-1:0] dm_rdata,
	output logic countdown_irq,
	output logic irq_pending,
	output logic irq_service
);
	// Register state
	logic [DATA_W-1:0] countdown_value; // Current count
	logic [DATA_W-1:0] reload_length; // Start value of each period
	logic [DATA_W-1:0] irq_mask_reg; // Interrupt mask word
	logic [DATA_W-1:0] next_countdown; // Count for the next edge
	logic [DATA_W-1:0] next_rdata; // Read mux result
	logic [DATA_W-1:0] flag_word; // Flag register as read
	logic wr_count; // Software writes the count this cycle
	logic wr_reload; // Software writes the reload this cycle
	logic wr_mask; // Software writes the mask this cycle
	logic wr_flag; // Software writes the flag register
	logic hit_zero; // Decrement lands on zero this cycle

	// Write decode
	always_comb begin
		wr_count = dm_req.wr && (dm_req.addr == COUNTDOWN_ADDR);
		wr_reload = dm_req.wr && (dm_req.addr == RELOAD_ADDR);
		wr_mask = dm_req.wr && (dm_req.addr == IRQ_MASK_ADDR);
		wr_flag = dm_req.wr && (dm_req.addr == IRQ_FLAG_ADDR);
	end

	// Next count: a software write wins, then reload after zero, else step down
	always_comb begin
		hit_zero = 1'b0;
		if (wr_count) begin
			// Direct load starts a fresh period without an event
			next_countdown = dm_req.wdata;
		end else if (countdown_value == COUNT_ZERO) begin
			// Zero lasted one cycle; reload gives period of reload plus one
			next_countdown = reload_length;
		end else begin
			next_countdown = countdown_value - COUNT_ONE;
			hit_zero = (countdown_value == COUNT_ONE);
		end
	end

	// Count register; held at all ones while reset stands
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			countdown_value <= COUNTDOWN_RST;
		end else begin
			countdown_value <= next_countdown;
		end
	end

	// First decrement lands on the first edge with reset low
	first_step_a: assert property (@(posedge clock) disable iff (sys_rst)
		($past(sys_rst) && !sys_rst && !wr_count)
		|=> countdown_value == COUNTDOWN_RST - COUNT_ONE)
		else $error("count did not start right after reset");

	// Reload register; a lone write does not touch the running count
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reload_length <= RELOAD_RST;
		end else if (wr_reload) begin
			reload_length <= dm_req.wdata;
		end
	end

	// Reload changes only by a software write
	reload_write_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && wr_reload) |=> reload_length == $past(dm_req.wdata))
		else $error("reload write not stored");
	reload_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && !wr_reload) |=> $stable(reload_length))
		else $error("reload changed without a write");

	// Mask register, plain storage; only the timer bit steers logic here
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_mask_reg <= IRQ_MASK_RST;
		end else if (wr_mask) begin
			irq_mask_reg <= dm_req.wdata;
		end
	end

	// Mask word takes the written value
	mask_write_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && wr_mask) |=> irq_mask_reg == $past(dm_req.wdata))
		else $error("mask write not stored");

	// Event pulse, one cycle, in the cycle the count shows zero
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			countdown_irq <= 1'b0;
		end else begin
			countdown_irq <= hit_zero;
		end
	end

	// Event is a single-cycle pulse and never missed on a step to zero
	irq_pulse_a: assert property (@(posedge clock) disable iff (sys_rst)
		countdown_irq |=> !countdown_irq)
		else $error("event longer than one cycle");
	irq_from_one_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && !wr_count && countdown_value == COUNT_ONE) |=> countdown_irq)
		else $error("step to zero raised no event");

	// Sticky flag; a new event beats a same-cycle clear so none is lost
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_pending <= 1'b0;
		end else if (countdown_irq) begin
			irq_pending <= 1'b1;
		end else if (irq_ack || (wr_flag && dm_req.wdata[TIMER_BIT])) begin
			irq_pending <= 1'b0;
		end
	end

	// Flag stays until cleared; a clear without a new event drops it
	flag_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && irq_pending && !irq_ack && !wr_flag) |=> irq_pending)
		else $error("flag dropped without a clear");
	flag_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && !countdown_irq && (irq_ack || (wr_flag && dm_req.wdata[TIMER_BIT])))
		|=> !irq_pending)
		else $error("flag not cleared");

	// Service request: flag and mask set, global disable clear
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_service <= 1'b0;
		end else begin
			irq_service <= irq_pending && irq_mask_reg[TIMER_BIT]
				&& !global_irq_disable;
		end
	end

	// Flag, mask and global enable together must start service
	service_on_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && irq_pending && irq_mask_reg[TIMER_BIT] && !global_irq_disable)
		|=> irq_service)
		else $error("service not requested");

	// Read mux; unmapped locations read zero
	always_comb begin
		flag_word = '0;
		flag_word[TIMER_BIT] = irq_pending;
		case (dm_req.addr)
			COUNTDOWN_ADDR: next_rdata = countdown_value;
			RELOAD_ADDR: next_rdata = reload_length;
			IRQ_MASK_ADDR: next_rdata = irq_mask_reg;
			IRQ_FLAG_ADDR: next_rdata = flag_word;
			default: next_rdata = '0;
		endcase
	end

	// Read data registered, valid the cycle after the read strobe
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			dm_rdata <= '0;
		end else if (dm_req.rd) begin
			dm_rdata <= next_rdata;
		end
	end

	// Read data holds between reads; reload reads back as stored
	rdata_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && !dm_req.rd) |=> $stable(dm_rdata))
		else $error("read data moved without a read");
	read_reload_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && dm_req.rd && dm_req.addr == RELOAD_ADDR)
		|=> dm_rdata == $past(reload_length))
		else $error("reload read back wrong");

	// Checks on the timer behaviour
	reset_value_a: assert property (@(posedge clock)
		sys_rst |=> (countdown_value == COUNTDOWN_RST) && (reload_length == RELOAD_RST))
		else $error("registers not all ones after reset");
	hold_reset_a: assert property (@(posedge clock)
		sys_rst ##1 sys_rst |-> countdown_value == COUNTDOWN_RST)
		else $error("count moved during reset");
	step_down_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && !wr_count && countdown_value != COUNT_ZERO)
		|=> countdown_value == $past(countdown_value) - COUNT_ONE)
		else $error("count did not step down by one");
	reload_copy_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && !wr_count && countdown_value == COUNT_ZERO)
		|=> countdown_value == $past(reload_length))
		else $error("reload not copied after zero");
	irq_at_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
		$past(!sys_rst) && countdown_irq |-> countdown_value == COUNT_ZERO && $past(!wr_count))
		else $error("event without count at zero");
	count_load_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && wr_count) |=> countdown_value == $past(dm_req.wdata) && !countdown_irq)
		else $error("count write wrong or raised event");
	reload_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && wr_reload && countdown_value > COUNT_ONE)
		|=> countdown_value == $past(countdown_value) - COUNT_ONE)
		else $error("reload write disturbed count");
	flag_set_a: assert property (@(posedge clock) disable iff (sys_rst)
		countdown_irq |=> irq_pending)
		else $error("event did not set flag");
	service_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
		$past(!sys_rst) && irq_service
		|-> $past(irq_pending && irq_mask_reg[TIMER_BIT] && !global_irq_disable))
		else $error("service without flag, mask and enable");
	read_back_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!sys_rst && dm_req.rd && dm_req.addr == COUNTDOWN_ADDR)
		|=> dm_rdata == $past(countdown_value))
		else $error("count read back wrong");
	// No event, flag or service survives a reset edge
	reset_quiet_a: assert property (@(posedge clock)
		sys_rst |=> !countdown_irq && !irq_pending && !irq_service)
		else $error("interrupt state not cleared by reset");
endmodule
